// ### rtl/acmp_ctrl.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acmp_ctrl (
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   input wire logic I_CLK_EN,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [acmp_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_CMP_RAW,
   input wire logic I_VECTOR_ACK,
   output logic O_CMP_POWER_DOWN,
   output logic O_BANDGAP_SELECT,
   output logic O_CMP_IRQ,
   output logic O_CAPTURE_SIGNAL,
   output logic O_CAPTURE_IRQ_ENABLE
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic disable_q;
   logic bandgap_q;
   logic flag_q;
   logic int_en_q;
   logic capture_q;
   acmp_pkg::acmp_mode_t mode_q;
   logic gie_q;
   logic capmask_q;
   logic irq_q;
   logic cap_sig_q;
   logic cap_irq_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic sync_level;
   logic access;
   logic wr_commit;
   logic csr_wr;
   logic aux_wr;
   logic flag_clr;
   acmp_pkg::acmp_sel_t sel;

   acmp_evt_if evt ();

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic acmp_pkg::acmp_sel_t decode(
      input logic [acmp_pkg::ADDR_W-1:0] a);
      acmp_pkg::acmp_sel_t s;
      s = acmp_pkg::SEL_NONE;
      if (a[1:0] != acmp_pkg::WORD_ALIGN)
         s = acmp_pkg::SEL_NONE;
      else if (a == acmp_pkg::CSR_OFFSET)
         s = acmp_pkg::SEL_CSR;
      else if (a == acmp_pkg::AUX_OFFSET)
         s = acmp_pkg::SEL_AUX;
      else
         s = acmp_pkg::SEL_NONE;
      return s;
   endfunction : decode

   function automatic logic [31:0] read_word(
      input acmp_pkg::acmp_sel_t s,
      input logic [7:0] csr,
      input logic [7:0] aux);
      logic [31:0] w;
      w = acmp_pkg::RDATA_ZERO;
      if (s == acmp_pkg::SEL_CSR)
         w[7:0] = csr;
      else if (s == acmp_pkg::SEL_AUX)
         w[7:0] = aux;
      else
         w = acmp_pkg::RDATA_ZERO;
      return w;
   endfunction : read_word

   logic [7:0] csr_view;
   logic [7:0] aux_view;

   always_comb
   begin
      csr_view = acmp_pkg::CSR_RESET;
      csr_view[acmp_pkg::BIT_DISABLE] = disable_q;
      csr_view[acmp_pkg::BIT_BANDGAP] = bandgap_q;
      csr_view[acmp_pkg::BIT_OUTPUT] = sync_level;
      csr_view[acmp_pkg::BIT_FLAG] = flag_q;
      csr_view[acmp_pkg::BIT_INT_EN] = int_en_q;
      csr_view[acmp_pkg::BIT_CAPTURE] = capture_q;
      csr_view[acmp_pkg::BIT_MODE_HI] = mode_q[1];
      csr_view[acmp_pkg::BIT_MODE_LO] = mode_q[0];
      aux_view = acmp_pkg::AUX_RESET;
      aux_view[acmp_pkg::AUX_BIT_GIE] = gie_q;
      aux_view[acmp_pkg::AUX_BIT_CAPMASK] = capmask_q;
   end

   assign sel = decode(I_PADDR);
   assign access = I_PSEL & I_PENABLE;
   assign wr_commit = access & pready_q & I_PWRITE;
   assign csr_wr = wr_commit & (sel == acmp_pkg::SEL_CSR) & I_PSTRB[0];
   assign aux_wr = wr_commit & (sel == acmp_pkg::SEL_AUX) & I_PSTRB[0];

   // ------------------------------------------------------------
   // APB slave, one wait state
   // ------------------------------------------------------------
   // Registered answer keeps every bus output a flop
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= acmp_pkg::RDATA_ZERO;
      end
      else if (I_CLK_EN)
      begin
         pready_q <= access & ~pready_q;
         if (access & ~pready_q)
         begin
            pslverr_q <= (sel == acmp_pkg::SEL_NONE);
            prdata_q <= I_PWRITE ? acmp_pkg::RDATA_ZERO
                                 : read_word(sel, csr_view, aux_view);
         end
         else
         begin
            pslverr_q <= 1'b0;
            prdata_q <= acmp_pkg::RDATA_ZERO;
         end
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         disable_q <= 1'b0;
         bandgap_q <= 1'b0;
         int_en_q <= 1'b0;
         capture_q <= 1'b0;
         mode_q <= acmp_pkg::MODE_TOGGLE;
      end
      else if (I_CLK_EN && csr_wr)
      begin
         disable_q <= I_PWDATA[acmp_pkg::BIT_DISABLE];
         bandgap_q <= I_PWDATA[acmp_pkg::BIT_BANDGAP];
         int_en_q <= I_PWDATA[acmp_pkg::BIT_INT_EN];
         capture_q <= I_PWDATA[acmp_pkg::BIT_CAPTURE];
         // No hardware guard against glitch events; software masks first
         mode_q <= acmp_pkg::acmp_mode_t'({I_PWDATA[acmp_pkg::BIT_MODE_HI],
                                           I_PWDATA[acmp_pkg::BIT_MODE_LO]});
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         gie_q <= 1'b0;
         capmask_q <= 1'b0;
      end
      else if (I_CLK_EN && aux_wr)
      begin
         gie_q <= I_PWDATA[acmp_pkg::AUX_BIT_GIE];
         capmask_q <= I_PWDATA[acmp_pkg::AUX_BIT_CAPMASK];
      end
   end

   // ------------------------------------------------------------
   // Comparator output path
   // ------------------------------------------------------------
   acmp_sync u_sync (
      .i_clock(I_CLOCK),
      .i_nrst(I_NRST),
      .i_clk_en(I_CLK_EN),
      .i_async(I_CMP_RAW),
      .o_sync(sync_level)
   );

   acmp_edge u_edge (
      .i_clock(I_CLOCK),
      .i_nrst(I_NRST),
      .i_clk_en(I_CLK_EN),
      .i_level(sync_level),
      .i_mode(mode_q),
      .evt(evt.edge_p)
   );

   // ------------------------------------------------------------
   // Flag and requests
   // ------------------------------------------------------------
   assign flag_clr = I_VECTOR_ACK | (csr_wr & I_PWDATA[acmp_pkg::BIT_FLAG]);

   // Set beats clear so a coincident event is kept
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
         flag_q <= 1'b0;
      else if (I_CLK_EN)
      begin
         if (evt.hit)
            flag_q <= 1'b1;
         else if (flag_clr)
            flag_q <= 1'b0;
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
         irq_q <= 1'b0;
      else if (I_CLK_EN)
         irq_q <= flag_q & int_en_q & gie_q;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_NRST)
      begin
         cap_sig_q <= 1'b0;
         cap_irq_q <= 1'b0;
      end
      else if (I_CLK_EN)
      begin
         cap_sig_q <= capture_q & evt.level;
         cap_irq_q <= capture_q & capmask_q;
      end
   end

   assign O_PRDATA = prdata_q;
   assign O_PREADY = pready_q;
   assign O_PSLVERR = pslverr_q;
   assign O_CMP_POWER_DOWN = disable_q;
   assign O_BANDGAP_SELECT = bandgap_q;
   assign O_CMP_IRQ = irq_q;
   assign O_CAPTURE_SIGNAL = cap_sig_q;
   assign O_CAPTURE_IRQ_ENABLE = cap_irq_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_power_down_write: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && csr_wr) |=>
         (O_CMP_POWER_DOWN == $past(I_PWDATA[acmp_pkg::BIT_DISABLE])))
      else $error("power down does not follow written bit");

   chk_bandgap_write: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && csr_wr) |=>
         (O_BANDGAP_SELECT == $past(I_PWDATA[acmp_pkg::BIT_BANDGAP])))
      else $error("bandgap select does not follow written bit");

   chk_sync_latency: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_NRST && I_CLK_EN)[*3] |-> (sync_level == $past(I_CMP_RAW, 2)))
      else $error("synchronized output not two cycles behind");

   chk_flag_set: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && evt.hit) |=> flag_q)
      else $error("event did not set flag");

   chk_flag_clear: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && flag_clr && !evt.hit) |=> !flag_q)
      else $error("flag not cleared");

   chk_irq_gate: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      I_CLK_EN |=> (O_CMP_IRQ == $past(flag_q && int_en_q && gie_q)))
      else $error("interrupt request gating wrong");

   chk_capture_route: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && !capture_q) |=> !O_CAPTURE_SIGNAL)
      else $error("capture path connected while disabled");

   chk_capture_mask: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      I_CLK_EN |=> (O_CAPTURE_IRQ_ENABLE == $past(capture_q && capmask_q)))
      else $error("capture interrupt enable wrong");

   chk_mode_reserved: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (mode_q == acmp_pkg::MODE_RESERVED) |-> !evt.hit)
      else $error("reserved mode produced an event");

   chk_rise_edge: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (mode_q == acmp_pkg::MODE_RISE && evt.hit) |-> (evt.level && !evt.prev))
      else $error("rising event without rising edge");

   chk_edge_once: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && evt.hit) |=> (evt.prev == $past(evt.level)))
      else $error("edge sample not advanced after event");

   chk_apb_wait: assert property (
      @(posedge I_CLOCK) disable iff (!I_NRST)
      (I_CLK_EN && access && !pready_q) |=> O_PREADY)
      else $error("access phase not answered");
endmodule : acmp_ctrl
`default_nettype wire

// ### shared/acmp_pkg.sv
`default_nettype none
package acmp_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CSR_OFFSET = 8'h00;
   localparam logic [7:0] AUX_OFFSET = 8'h04;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] AUX_RESET = 8'h00;
   localparam logic [1:0] WORD_ALIGN = 2'h0;
   localparam logic [31:0] RDATA_ZERO = 32'h0;
   // ------------------------------------------------------------
   // Control and status fields
   // ------------------------------------------------------------
   localparam int unsigned BIT_DISABLE = 7;
   localparam int unsigned BIT_BANDGAP = 6;
   localparam int unsigned BIT_OUTPUT = 5;
   localparam int unsigned BIT_FLAG = 4;
   localparam int unsigned BIT_INT_EN = 3;
   localparam int unsigned BIT_CAPTURE = 2;
   localparam int unsigned BIT_MODE_HI = 1;
   localparam int unsigned BIT_MODE_LO = 0;
   localparam int unsigned AUX_BIT_GIE = 0;
   localparam int unsigned AUX_BIT_CAPMASK = 1;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_TOGGLE = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_FALL = 2'h2,
      MODE_RISE = 2'h3
   } acmp_mode_t;
   typedef enum logic [1:0] {
      SEL_CSR,
      SEL_AUX,
      SEL_NONE
   } acmp_sel_t;
endpackage : acmp_pkg
`default_nettype wire

// ### shared/acmp_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acmp_evt_if;
   logic level;
   logic prev;
   logic hit;
   modport edge_p (output level, output prev, output hit);
   modport ctrl_p (input level, input prev, input hit);
endinterface : acmp_evt_if
`default_nettype wire

// ### rtl/acmp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acmp_sync (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_q;
   logic sync_q;

   // ------------------------------------------------------------
   // Two stages, first one read only by the second
   // ------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : acmp_sync
`default_nettype wire

// ### rtl/acmp_edge.sv
`timescale 1ns/1ps
`default_nettype none
module acmp_edge (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_clk_en,
   input wire logic i_level,
   input wire acmp_pkg::acmp_mode_t i_mode,
   acmp_evt_if.edge_p evt
);
   logic prev_q;

   // ------------------------------------------------------------
   // Event decode
   // ------------------------------------------------------------
   function automatic logic mode_hit(input acmp_pkg::acmp_mode_t m,
                                     input logic cur, input logic old);
      logic r;
      r = 1'b0;
      case (m)
         acmp_pkg::MODE_TOGGLE: r = cur ^ old;
         acmp_pkg::MODE_FALL: r = old & ~cur;
         acmp_pkg::MODE_RISE: r = cur & ~old;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : mode_hit

   // Previous sample, so each transition fires once
   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
         prev_q <= 1'b0;
      else if (i_clk_en)
         prev_q <= i_level;
   end

   assign evt.level = i_level;
   assign evt.prev = prev_q;
   assign evt.hit = mode_hit(i_mode, i_level, prev_q);
endmodule : acmp_edge
`default_nettype wire

// ### bench/acmp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acmp_core_model (
   input wire logic i_power_down,
   input wire logic i_bandgap_select,
   input wire logic i_pin_above,
   input wire logic i_gap_above,
   output logic o_raw
);
   // ------------------------------------------------------------
   // Analog decision
   // ------------------------------------------------------------
   // Powered off: steady low, so no stale level leaks through
   always_comb
   begin
      if (i_power_down)
      begin
         o_raw = 1'b0;
      end
      else if (i_bandgap_select)
      begin
         o_raw = i_gap_above;
      end
      else
      begin
         o_raw = i_pin_above;
      end
   end
endmodule : acmp_core_model
`default_nettype wire

// ### bench/acmp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acmp_ctrl_tb;
   localparam logic [7:0] CSR = acmp_pkg::CSR_OFFSET;
   localparam logic [7:0] AUX = acmp_pkg::AUX_OFFSET;
   logic clk, nrst, psel, penable, pwrite, ack, pin_above, gap_above, raw, err, clk_en;
   logic [3:0] pstrb;
   logic pready, pslverr, pdown, bgsel, irq, cap, capirq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] modes [3];
   int failures, check_count, cyc;
   // ------------------------------------------------------------
   // Design and comparator core
   // ------------------------------------------------------------
   acmp_ctrl dut (
      .I_CLOCK(clk), .I_NRST(nrst), .I_CLK_EN(clk_en), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_CMP_RAW(raw), .I_VECTOR_ACK(ack), .O_CMP_POWER_DOWN(pdown),
      .O_BANDGAP_SELECT(bgsel), .O_CMP_IRQ(irq), .O_CAPTURE_SIGNAL(cap),
      .O_CAPTURE_IRQ_ENABLE(capirq)
   );
   acmp_core_model core (
      .i_power_down(pdown), .i_bandgap_select(bgsel), .i_pin_above(pin_above),
      .i_gap_above(gap_above), .o_raw(raw)
   );
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         failures++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_n
   // Entered just after an edge; leaves one idle edge so no signal is set twice
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      check("wait", 32'(n), 32'h2);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rdf(input logic exp);
      apb(1'b0, CSR, 32'h0);
      check("flag", 32'(rd[4]), 32'(exp));
   endtask : rdf
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial
   begin
      modes = '{acmp_pkg::MODE_TOGGLE, acmp_pkg::MODE_FALL, acmp_pkg::MODE_RISE};
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ack = 1'b0;
      clk_en = 1'b1;
      pstrb = 4'h1;
      pin_above = 1'b0;
      gap_above = 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      wait_n(3);
      check("pdown", 32'(pdown), 32'h0);
      apb(1'b0, CSR, 32'h0);
      check("csr", rd, 32'h0);
      apb(1'b0, AUX, 32'h0);
      check("aux", rd, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      check("err", 32'(err), 32'h1);
      check("rdata", rd, 32'h0);
      apb(1'b1, 8'h01, 32'h80);
      check("err", 32'(err), 32'h1);
      // Status bit is read-only, upper bits not stored
      apb(1'b1, CSR, 32'hffffff24);
      apb(1'b0, CSR, 32'h0);
      check("csr", rd, 32'h04);
      pin_above <= 1'b1;
      apb(1'b1, CSR, 32'h40);
      wait_n(4);
      check("bgsel", 32'(bgsel), 32'h1);
      apb(1'b0, CSR, 32'h0);
      check("out", 32'(rd[5]), 32'h0);
      apb(1'b1, CSR, 32'h00);
      wait_n(4);
      apb(1'b0, CSR, 32'h0);
      check("out", 32'(rd[5]), 32'h1);
      check("bgsel", 32'(bgsel), 32'h0);
      apb(1'b1, CSR, 32'h80);
      check("pdown", 32'(pdown), 32'h1);
      apb(1'b1, CSR, 32'h11);
      check("pdown", 32'(pdown), 32'h0);
      apb(1'b0, CSR, 32'h0);
      check("mode", 32'(rd[1:0]), 32'h1);
      for (int i = 0; i < 3; i++)
      begin
         pin_above <= 1'b0;
         wait_n(4);
         apb(1'b1, CSR, 32'h10 | 32'(modes[i]));
         pin_above <= 1'b1;
         wait_n(4);
         rdf(modes[i] != acmp_pkg::MODE_FALL);
         apb(1'b1, CSR, 32'(modes[i]));
         rdf(modes[i] != acmp_pkg::MODE_FALL);
         apb(1'b1, CSR, 32'h10 | 32'(modes[i]));
         rdf(1'b0);
         pin_above <= 1'b0;
         wait_n(4);
         rdf(modes[i] != acmp_pkg::MODE_RISE);
      end
      apb(1'b1, AUX, 32'h1);
      apb(1'b1, CSR, 32'h13);
      pin_above <= 1'b1;
      wait_n(4);
      check("irq", 32'(irq), 32'h0);
      apb(1'b1, CSR, 32'h0b);
      wait_n(2);
      check("irq", 32'(irq), 32'h1);
      apb(1'b1, AUX, 32'h0);
      wait_n(2);
      check("irq", 32'(irq), 32'h0);
      apb(1'b1, AUX, 32'h1);
      wait_n(2);
      check("irq", 32'(irq), 32'h1);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      wait_n(3);
      check("irq", 32'(irq), 32'h0);
      rdf(1'b0);
      pin_above <= 1'b0;
      wait_n(4);
      pin_above <= 1'b1;
      wait_n(5);
      check("irq", 32'(irq), 32'h1);
      apb(1'b1, CSR, 32'h03);
      wait_n(2);
      check("irq", 32'(irq), 32'h0);
      apb(1'b1, CSR, 32'h07);
      wait_n(5);
      check("cap", 32'(cap), 32'h1);
      check("capirq", 32'(capirq), 32'h0);
      apb(1'b1, AUX, 32'h3);
      wait_n(2);
      check("capirq", 32'(capirq), 32'h1);
      pin_above <= 1'b0;
      wait_n(2);
      check("cap", 32'(cap), 32'h1);
      wait_n(4);
      check("cap", 32'(cap), 32'h0);
      apb(1'b1, CSR, 32'h03);
      pin_above <= 1'b1;
      wait_n(5);
      check("cap", 32'(cap), 32'h0);
      check("capirq", 32'(capirq), 32'h0);
      // Write with its low byte strobe off must be ignored
      pstrb <= 4'h0;
      apb(1'b1, CSR, 32'h80);
      check("pdown", 32'(pdown), 32'h0);
      pstrb <= 4'h1;
      apb(1'b1, CSR, 32'h07);
      wait_n(4);
      check("cap", 32'(cap), 32'h1);
      // Enable low freezes the whole path
      clk_en <= 1'b0;
      pin_above <= 1'b0;
      wait_n(6);
      check("cap", 32'(cap), 32'h1);
      clk_en <= 1'b1;
      wait_n(5);
      check("cap", 32'(cap), 32'h0);
      close_out();
   end
endmodule : acmp_ctrl_tb
`default_nettype wire
